//--- wcrc_pkg.sv
package wcrc_pkg;

    // ****************************************
    // Register map
    // ****************************************
    localparam int          ADDR_W               = 8;
    localparam logic [7:0]  REG_CTRL             = 8'h00;
    localparam logic [7:0]  REG_MODE_REG_FIVE    = 8'h04;
    localparam logic [7:0]  REG_MPR_THREE        = 8'h08;
    localparam logic [7:0]  REG_ERR_COUNT        = 8'h0C;
    localparam logic [7:0]  REG_LAST_CRC         = 8'h10;

    localparam int          CTRL_CRC_EN_BIT      = 0;
    localparam int          CTRL_DM_EN_BIT       = 1;
    localparam int          CTRL_DBI_EN_BIT      = 2;
    localparam int          CTRL_WIDTH_LSB       = 4;
    localparam int          MODE5_ERR_CLR_BIT    = 3;
    localparam int          MPR_ERR_STATUS_BIT   = 0;
    localparam int          MPR_ALERT_LINE_BIT   = 1;
    localparam logic [31:0] CTRL_RESET           = 32'h0000_0000;
    localparam logic [7:0]  ERR_COUNT_RESET      = 8'h00;

    // ****************************************
    // Frame and timing
    // ****************************************
    localparam int          CW_W                 = 72;
    localparam int          CRC_W                = 8;
    localparam int          LANES                = 16;
    localparam logic [3:0]  LAST_DATA_XFER       = 4'h7;
    localparam logic [3:0]  CRC_LO_XFER          = 4'h8;
    localparam logic [3:0]  CRC_HI_XFER          = 4'h9;
    localparam int          CLK_MHZ              = 20;
    localparam int          ALERT_LAT_MIN_NS     = 3;
    localparam int          ALERT_LAT_MAX_NS     = 13;
    localparam int          ALERT_LAT_RAW        = ALERT_LAT_MAX_NS * CLK_MHZ / 1000;
    localparam int          ALERT_LAT_CYC        = (ALERT_LAT_RAW < 1) ? 1 : ALERT_LAT_RAW;
    localparam int          ALERT_PW_MIN_CYC     = 6;
    localparam int          ALERT_PW_MAX_CYC     = 10;
    localparam logic [7:0]  CRC_POLY             = 8'h07;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        WCRC_X4  = 2'h0,
        WCRC_X8  = 2'h1,
        WCRC_X16 = 2'h2
    } wcrc_width_e;

    typedef enum logic [2:0] {
        WCRC_IDLE = 3'b001,
        WCRC_RECV = 3'b010,
        WCRC_CALC = 3'b100
    } wcrc_state_e;

    typedef struct packed {
        logic        crc_en;
        logic        dm_en;
        logic        dbi_en;
        wcrc_width_e width;
    } wcrc_ctrl_s;

    typedef struct packed {
        logic        link_clk;
        logic        frame;
        logic [15:0] dq;
        logic [1:0]  inv;
        logic        alert_in;
    } wcrc_pins_s;

endpackage

//--- wcrc_tree.sv
`timescale 1ns/1ps

module wcrc_tree #(
    parameter int CW_W = wcrc_pkg::CW_W
) (
    input  wire logic            clock,
    input  wire logic            rstn,
    input  wire logic            start,
    input  wire logic [CW_W-1:0] code_word,
    output logic      [7:0]      crc,
    output logic                 done
);

    // ****************************************
    // Serial form of the checksum tree
    // ****************************************
    function automatic logic [7:0] crc_of(input logic [CW_W-1:0] d);
        logic [7:0] c;
        logic       fb;
        c  = 8'h00;
        fb = 1'b0;
        for (int i = CW_W - 1; i >= 0; i--) begin
            fb = c[7] ^ d[i];
            c  = {c[6:0], 1'b0} ^ (fb ? wcrc_pkg::CRC_POLY : 8'h00);
        end
        return c;
    endfunction

    typedef struct packed {
        logic [7:0] crc;
        logic       done;
    } wcrc_tree_s;

    wcrc_tree_s cur;
    wcrc_tree_s next_cur;

    always_comb begin
        next_cur      = cur;
        next_cur.done = start;
        if (start) begin
            next_cur.crc = crc_of(code_word);
        end
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign crc  = cur.crc;
    assign done = cur.done;

    generate
        if (CW_W < 8) begin : g_bad_width
            $error("Code word narrower than checksum");
        end
    endgenerate

endmodule // wcrc_tree

//--- wcrc_check.sv
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/1ps

// Function
// - Recompute, compare, alert on mismatch
// - Byte tree: top eight from mask/inversion
// - Word part: two trees, tops as in the byte tree
// - Nibble part: upper forty inputs one
// - Commit data before the comparison ends
// - Low byte covers low word
// - Share alert with parity errors
// - Alert pulse six to ten clocks
// - Error sets clear and status bits
// - Clear bit holds until host write
// - Alert within three to thirteen ns; here alert_oe rises one 50 ns clock after the trees report done
// - Device only pulls alert low
// - Nibble lane and checksum mapping
// - Byte lane and checksum mapping
// - Polynomial x8 + x2 + x + 1
// - Zero start, bit 71 first
module wcrc_check #(
    parameter int PULSE_CYC = wcrc_pkg::ALERT_PW_MIN_CYC
) (
    input  wire logic         clock,
    input  wire logic         rstn,
    input  wire logic         link_clk,
    input  wire logic         frame,
    input  wire logic [15:0]  dq,
    input  wire logic         lower_invert_lane,
    input  wire logic         upper_invert_lane,
    input  wire logic         alert_in,
    output logic              alert_o,
    output logic              alert_oe,
    input  wire logic         parity_alert,
    input  wire logic [7:0]   reg_addr,
    input  wire logic [31:0]  reg_wdata,
    input  wire logic         reg_wr,
    input  wire logic         reg_rd,
    output logic      [31:0]  reg_rdata,
    output logic              arr_valid,
    output logic      [127:0] arr_data,
    output logic      [15:0]  arr_mask
);

    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        wcrc_pkg::wcrc_state_e st;
        wcrc_pkg::wcrc_pins_s  s1;
        wcrc_pkg::wcrc_pins_s  s2;
        logic                  link_prev;
        logic [3:0]            xfer;
        logic [15:0][7:0]      lane_bits;
        logic [1:0][7:0]       inv_bits;
        logic [15:0]           rx_crc;
        logic [15:0]           calc_crc;
        logic                  calc_go;
        wcrc_pkg::wcrc_ctrl_s  ctrl;
        logic                  clr_bit;
        logic                  stat_bit;
        logic [7:0]            err_cnt;
        logic                  err_evt;
        logic                  crc_pulse;
        logic [3:0]            pw_cnt;
        logic                  alert_o;
        logic                  alert_oe;
        logic [31:0]           rdata;
        logic                  arr_valid;
        logic [127:0]          arr_data;
        logic [15:0]           arr_mask;
    } wcrc_state_s;

    wcrc_state_s          cur;
    wcrc_state_s          next_cur;
    wcrc_pkg::wcrc_pins_s pins;
    logic [1:0][71:0]     code_word;
    logic [1:0][7:0]      tree_crc;
    logic [1:0]           tree_done;
    logic                 is_x4;
    logic                 is_x16;
    logic                 link_rise;
    logic                 mismatch;

    assign pins      = '{link_clk: link_clk, frame: frame, dq: dq,
                         inv: {upper_invert_lane, lower_invert_lane}, alert_in: alert_in};
    assign is_x4     = cur.ctrl.width == wcrc_pkg::WCRC_X4;
    assign is_x16    = cur.ctrl.width == wcrc_pkg::WCRC_X16;
    assign link_rise = cur.s2.link_clk && !cur.link_prev;

    // ****************************************
    // Code words and checksum trees
    // ****************************************
    function automatic logic [71:0] build_cw(input logic [15:0][7:0] lb, input logic [1:0][7:0] ib,
                                             input wcrc_pkg::wcrc_ctrl_s c, input int g);
        logic [71:0] w;
        w = '1;
        for (int l = 0; l < 8; l++) begin
            if (c.width != wcrc_pkg::WCRC_X4 || l < 4) begin
                w[l*8 +: 8] = lb[g*8+l];
            end
        end
        if (c.width != wcrc_pkg::WCRC_X4 && (c.dm_en || c.dbi_en)) begin
            w[71:64] = ib[g];
        end
        return w;
    endfunction

    generate
        for (genvar g = 0; g < 2; g++) begin : g_tree
            assign code_word[g] = build_cw(cur.lane_bits, cur.inv_bits, cur.ctrl, g);
            wcrc_tree #(
                .CW_W      (wcrc_pkg::CW_W)
            ) u_tree (
                .clock     (clock),
                .rstn      (rstn),
                .start     (cur.calc_go),
                .code_word (code_word[g]),
                .crc       (tree_crc[g]),
                .done      (tree_done[g])
            );
        end
    endgenerate

    // Upper tree only counts on the word part
    assign mismatch = (tree_crc[0] != cur.rx_crc[7:0])
                   || (is_x16 && tree_crc[1] != cur.rx_crc[15:8]);

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        next_cur           = cur;
        next_cur.s1        = pins;
        next_cur.s2        = cur.s1;
        next_cur.link_prev = cur.s2.link_clk;
        next_cur.calc_go   = 1'b0;
        next_cur.err_evt   = 1'b0;
        next_cur.arr_valid = 1'b0;
        next_cur.rdata     = 32'h0000_0000;
        next_cur.alert_o   = 1'b0;

        // Register writes; hardware sets below win over clears
        if (reg_wr) begin
            case (reg_addr)
                wcrc_pkg::REG_CTRL: begin
                    next_cur.ctrl.crc_en = reg_wdata[wcrc_pkg::CTRL_CRC_EN_BIT];
                    next_cur.ctrl.dm_en  = reg_wdata[wcrc_pkg::CTRL_DM_EN_BIT];
                    next_cur.ctrl.dbi_en = reg_wdata[wcrc_pkg::CTRL_DBI_EN_BIT];
                    next_cur.ctrl.width  = wcrc_pkg::wcrc_width_e'(reg_wdata[wcrc_pkg::CTRL_WIDTH_LSB +: 2]);
                end
                wcrc_pkg::REG_MODE_REG_FIVE: begin
                    if (!reg_wdata[wcrc_pkg::MODE5_ERR_CLR_BIT]) begin
                        next_cur.clr_bit  = 1'b0;
                        next_cur.stat_bit = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end

        // Register reads
        if (reg_rd) begin
            case (reg_addr)
                wcrc_pkg::REG_CTRL: begin
                    next_cur.rdata[wcrc_pkg::CTRL_CRC_EN_BIT]       = cur.ctrl.crc_en;
                    next_cur.rdata[wcrc_pkg::CTRL_DM_EN_BIT]        = cur.ctrl.dm_en;
                    next_cur.rdata[wcrc_pkg::CTRL_DBI_EN_BIT]       = cur.ctrl.dbi_en;
                    next_cur.rdata[wcrc_pkg::CTRL_WIDTH_LSB +: 2]   = cur.ctrl.width;
                end
                wcrc_pkg::REG_MODE_REG_FIVE: begin
                    next_cur.rdata[wcrc_pkg::MODE5_ERR_CLR_BIT]     = cur.clr_bit;
                end
                wcrc_pkg::REG_MPR_THREE: begin
                    next_cur.rdata[wcrc_pkg::MPR_ERR_STATUS_BIT]    = cur.stat_bit;
                    next_cur.rdata[wcrc_pkg::MPR_ALERT_LINE_BIT]    = cur.s2.alert_in;
                end
                wcrc_pkg::REG_ERR_COUNT: begin
                    next_cur.rdata[7:0] = cur.err_cnt;
                end
                wcrc_pkg::REG_LAST_CRC: begin
                    next_cur.rdata = {cur.rx_crc, cur.calc_crc};
                end
                default: begin
                    next_cur.rdata = 32'h0000_0000;
                end
            endcase
        end

        // Frame capture, one transfer per link clock rise
        case (cur.st)
            wcrc_pkg::WCRC_IDLE, wcrc_pkg::WCRC_RECV: begin
                if (cur.st == wcrc_pkg::WCRC_RECV && !cur.s2.frame) begin
                    next_cur.st   = wcrc_pkg::WCRC_IDLE;
                    next_cur.xfer = 4'h0;
                end else if (link_rise && cur.s2.frame) begin
                    next_cur.st   = wcrc_pkg::WCRC_RECV;
                    next_cur.xfer = cur.xfer + 4'h1;
                    if (cur.xfer <= wcrc_pkg::LAST_DATA_XFER) begin
                        for (int l = 0; l < wcrc_pkg::LANES; l++) begin
                            next_cur.lane_bits[l][cur.xfer[2:0]] = cur.s2.dq[l];
                        end
                        for (int i = 0; i < 2; i++) begin
                            next_cur.inv_bits[i][cur.xfer[2:0]] = cur.s2.inv[i];
                        end
                    end
                    if (cur.xfer == wcrc_pkg::LAST_DATA_XFER) begin
                        next_cur.arr_valid = 1'b1;
                        next_cur.arr_data  = next_cur.lane_bits;
                        next_cur.arr_mask  = next_cur.inv_bits;
                        if (!cur.ctrl.crc_en) begin
                            next_cur.st   = wcrc_pkg::WCRC_IDLE;
                            next_cur.xfer = 4'h0;
                        end
                    end
                    if (cur.xfer == wcrc_pkg::CRC_LO_XFER) begin
                        if (is_x4) begin
                            next_cur.rx_crc[3:0] = cur.s2.dq[3:0];
                        end else begin
                            next_cur.rx_crc = cur.s2.dq;
                        end
                    end
                    if (cur.xfer == wcrc_pkg::CRC_HI_XFER) begin
                        if (is_x4) begin
                            next_cur.rx_crc[7:4] = cur.s2.dq[3:0];
                        end
                        next_cur.st      = wcrc_pkg::WCRC_CALC;
                        next_cur.xfer    = 4'h0;
                        next_cur.calc_go = 1'b1;
                    end
                end
            end
            wcrc_pkg::WCRC_CALC: begin
                if (tree_done[0]) begin
                    next_cur.st       = wcrc_pkg::WCRC_IDLE;
                    next_cur.calc_crc = {tree_crc[1], tree_crc[0]};
                    if (cur.ctrl.crc_en && mismatch) begin
                        next_cur.err_evt   = 1'b1;
                        next_cur.clr_bit   = 1'b1;
                        next_cur.stat_bit  = 1'b1;
                        next_cur.crc_pulse = 1'b1;
                        next_cur.pw_cnt    = 4'h0;
                        if (cur.err_cnt != 8'hFF) begin
                            next_cur.err_cnt = cur.err_cnt + 8'h01;
                        end
                    end
                end
            end
            default: begin
                next_cur.st   = wcrc_pkg::WCRC_IDLE;
                next_cur.xfer = 4'h0;
            end
        endcase

        // Alert pulse of fixed width
        if (cur.crc_pulse && !next_cur.err_evt) begin
            if (cur.pw_cnt == 4'(PULSE_CYC - 1)) begin
                next_cur.crc_pulse = 1'b0;
            end else begin
                next_cur.pw_cnt = cur.pw_cnt + 4'h1;
            end
        end
        next_cur.alert_oe = next_cur.crc_pulse || parity_alert;
    end

    always_ff @(posedge clock) begin
        if (!rstn) begin
            cur          <= '0;
            cur.st       <= wcrc_pkg::WCRC_IDLE;
            cur.ctrl     <= wcrc_pkg::wcrc_ctrl_s'(5'h00);
            cur.err_cnt  <= wcrc_pkg::ERR_COUNT_RESET;
        end else begin
            cur <= next_cur;
        end
    end

    assign alert_o   = cur.alert_o;
    assign alert_oe  = cur.alert_oe;
    assign reg_rdata = cur.rdata;
    assign arr_valid = cur.arr_valid;
    assign arr_data  = cur.arr_data;
    assign arr_mask  = cur.arr_mask;

    generate
        if (PULSE_CYC < wcrc_pkg::ALERT_PW_MIN_CYC || PULSE_CYC > wcrc_pkg::ALERT_PW_MAX_CYC) begin : g_bad_pw
            $error("Alert pulse width out of range");
        end
        if (wcrc_pkg::ALERT_LAT_CYC < 1) begin : g_bad_lat
            $error("Alert latency below one cycle");
        end
    endgenerate

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!rstn);

    property p_pulse_width;
        $rose(cur.crc_pulse) |-> cur.crc_pulse [*6] ##[1:5] !cur.crc_pulse;
    endproperty
    a_pulse_width: assert property (p_pulse_width) else $error("Alert pulse width wrong");

    property p_alert_latency;
        cur.err_evt |-> alert_oe && cur.crc_pulse;
    endproperty
    a_alert_latency: assert property (p_alert_latency) else $error("Alert late");

    property p_mismatch_flags;
        cur.st == wcrc_pkg::WCRC_CALC && tree_done[0] && cur.ctrl.crc_en && mismatch
            |=> cur.err_evt && cur.clr_bit && cur.stat_bit;
    endproperty
    a_mismatch_flags: assert property (p_mismatch_flags) else $error("Mismatch not flagged");

    property p_clear_holds;
        cur.clr_bit && !(reg_wr && reg_addr == wcrc_pkg::REG_MODE_REG_FIVE) |=> cur.clr_bit;
    endproperty
    a_clear_holds: assert property (p_clear_holds) else $error("Clear bit dropped");

    property p_disabled_quiet;
        !cur.ctrl.crc_en |=> !cur.err_evt;
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet) else $error("Error while disabled");

    property p_pull_low_only;
        alert_oe |-> !alert_o;
    endproperty
    a_pull_low_only: assert property (p_pull_low_only) else $error("Alert driven high");

    property p_parity_shared;
        parity_alert |=> alert_oe;
    endproperty
    a_parity_shared: assert property (p_parity_shared) else $error("Parity alert lost");

    property p_nibble_tops;
        cur.calc_go && is_x4 |-> code_word[0][71:32] == '1;
    endproperty
    a_nibble_tops: assert property (p_nibble_tops) else $error("Nibble upper inputs not one");

    property p_byte_tops;
        cur.calc_go && !is_x4 && !cur.ctrl.dm_en && !cur.ctrl.dbi_en
            |-> code_word[0][71:64] == 8'hFF && code_word[1][71:64] == 8'hFF;
    endproperty
    a_byte_tops: assert property (p_byte_tops) else $error("Top inputs not one");

    property p_early_commit;
        link_rise && cur.s2.frame && cur.st != wcrc_pkg::WCRC_CALC && cur.xfer == wcrc_pkg::LAST_DATA_XFER
            && !(cur.st == wcrc_pkg::WCRC_RECV && !cur.s2.frame) |=> arr_valid ##1 !arr_valid;
    endproperty
    a_early_commit: assert property (p_early_commit) else $error("Data not committed");

endmodule // wcrc_check

//--- wcrc_ctrl_model.sv
`timescale 1ns/1ps
module wcrc_ctrl_model (
    output logic        link_clk,
    output logic        frame,
    output logic [15:0] dq,
    output logic        lower_invert_lane,
    output logic        upper_invert_lane
);
    // ****************
    // Write frames
    // ****************
    initial begin
        link_clk = 1'b0;
        frame = 1'b0;
        dq = 16'h0000;
        lower_invert_lane = 1'b0;
        upper_invert_lane = 1'b0;
    end
    function automatic logic [7:0] crc8(input logic [71:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 71; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic send(input logic [1:0] w, input logic top, input logic on, input logic [127:0] d,
                        input logic [15:0] inv, input logic [15:0] flip);
        logic [71:0] lo;
        logic [15:0] crc;
        lo = (w == wcrc_pkg::WCRC_X4) ? {40'hff_ffff_ffff, d[31:0]} : {top ? inv[7:0] : 8'hff, d[63:0]};
        crc = {crc8({top ? inv[15:8] : 8'hff, d[127:64]}), crc8(lo)} ^ flip;
        frame = 1'b1;
        for (int t = 0; t < (on ? 10 : 8); t++) begin
            for (int l = 0; l < 16; l++) dq[l] = d[l*8+t%8];
            if (t == 8) dq = (w == wcrc_pkg::WCRC_X4) ? {12'hfff, crc[3:0]} : crc;
            if (t == 9) dq = (w == wcrc_pkg::WCRC_X4) ? {12'hfff, crc[7:4]} : 16'hffff;
            lower_invert_lane = (t < 8) ? inv[t] : 1'b1;
            upper_invert_lane = (t < 8) ? inv[8+t] : 1'b1;
            #200 link_clk = 1'b1;
            #200 link_clk = 1'b0;
        end
        frame = 1'b0;
        // Released lanes show no stale value
        dq = ~dq;
        #800;
    endtask
endmodule // wcrc_ctrl_model

//--- wcrc_check_tb_top.sv
`timescale 1ns/1ps
module wcrc_check_tb_top;
    typedef struct {
        logic [1:0]  w;
        logic [1:0]  fn;
        logic [31:0] s;
        logic [15:0] inv;
        logic [15:0] flip;
    } wcrc_row_s;
    localparam int         PW     = 7;
    localparam logic [7:0] A_CLR  = wcrc_pkg::REG_MODE_REG_FIVE;
    localparam logic [7:0] A_STAT = wcrc_pkg::REG_MPR_THREE;
    logic         clock = 1'b0;
    logic         rstn = 1'b0;
    logic         parity_alert = 1'b0;
    logic [7:0]   reg_addr = 8'h00;
    logic [31:0]  reg_wdata = 32'h0000_0000;
    logic         reg_wr = 1'b0;
    logic         reg_rd = 1'b0;
    logic [31:0]  reg_rdata;
    logic         link_clk;
    logic         frame;
    logic [15:0]  dq;
    logic         lower_invert_lane;
    logic         upper_invert_lane;
    logic         alert_o;
    logic         alert_oe;
    wire logic    alert_in;
    logic         arr_valid;
    logic [127:0] arr_data;
    logic [15:0]  arr_mask;
    logic [127:0] last_d;
    logic [15:0]  last_m;
    int           bad_count = 0;
    int           compares = 0;
    int           pulses = 0;
    int           run = 0;
    int           width = 0;
    int           arrs = 0;
    wcrc_row_s    rows [7] = '{
        '{2'h0, 2'h0, 32'h1234_5678, 16'hffff, 16'h0000},
        '{2'h0, 2'h0, 32'hdead_beef, 16'hffff, 16'h0010},
        '{2'h1, 2'h2, 32'h0f0f_a5a5, 16'hff3c, 16'h0000},
        '{2'h1, 2'h0, 32'h8000_0001, 16'hff5a, 16'h0000},
        '{2'h2, 2'h1, 32'hcafe_f00d, 16'h6a95, 16'h0000},
        '{2'h2, 2'h2, 32'h0000_0000, 16'h00ff, 16'h0100},
        '{2'h1, 2'h1, 32'h7777_1111, 16'hffc3, 16'h0001}
    };

    wcrc_check #(.PULSE_CYC(PW)) wcrc_check_inst (.clock, .rstn, .link_clk, .frame, .dq, .lower_invert_lane,
        .upper_invert_lane, .alert_in, .alert_o, .alert_oe, .parity_alert, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .arr_valid, .arr_data, .arr_mask);
    wcrc_ctrl_model wcrc_ctrl_model_inst (.link_clk, .frame, .dq, .lower_invert_lane, .upper_invert_lane);
    assign alert_in = alert_oe ? alert_o : 1'b1;

    // ****************
    // Monitors and tasks
    // ****************
    initial begin
        forever #25 clock = ~clock;
    end
    always @(posedge clock) begin
        if (arr_valid === 1'b1) begin
            arrs <= arrs + 1;
            last_d <= arr_data;
            last_m <= arr_mask;
        end
        if (alert_in === 1'b0) begin
            run <= run + 1;
        end else if (run != 0) begin
            pulses <= pulses + 1;
            width <= run;
            run <= 0;
        end
    end
    task automatic chk(input string n, input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", n, exp, seen);
        end
    endtask
    task automatic finish_test();
        if (bad_count == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask
    task automatic wait_pulse(input int n0);
        for (int i = 0; i < 40 && pulses == n0; i++) @(posedge clock);
        if (pulses == n0) begin
            bad_count++;
            finish_test();
        end
    endtask

    // ****************
    // Stimulus
    // ****************
    initial begin
        wcrc_row_s   r;
        logic [127:0] d;
        logic [31:0] v;
        int          p0;
        int          a0;
        logic        e;
        int          nb = 0;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        repeat (3) @(posedge clock);
        chk("alert_oe", alert_oe, 1'b0);
        rd(wcrc_pkg::REG_CTRL, v);
        chk("ctrl", v, wcrc_pkg::CTRL_RESET);
        rd(wcrc_pkg::REG_ERR_COUNT, v);
        chk("err_count", v, wcrc_pkg::ERR_COUNT_RESET);
        rd(8'hf0, v);
        chk("unmapped", v, 32'h0000_0000);
        foreach (rows[i]) begin
            r = rows[i];
            d = (r.w == 2'h0) ? {{96{1'b1}}, r.s} : (r.w == 2'h1) ? {{64{1'b1}}, r.s, ~r.s} : {r.s, ~r.s, ~r.s, r.s};
            wr(wcrc_pkg::REG_CTRL, {26'h0, r.w, 1'b0, r.fn[1], r.fn[0], 1'b1});
            p0 = pulses;
            a0 = arrs;
            wcrc_ctrl_model_inst.send(r.w, |r.fn, 1'b1, d, r.inv, r.flip);
            e = (r.flip != 16'h0000);
            nb += e;
            if (e) wait_pulse(p0);
            chk("pulses", pulses, p0 + e);
            chk("arr_data", last_d, d);
            chk("arr_mask", last_m, r.inv);
            chk("arr_count", arrs, a0 + 1);
            rd(A_STAT, v);
            chk("status", v[0], e);
            chk("alert_line", v[1], 1'b1);
            if (e) begin
                chk("width", width, PW);
                wr(A_CLR, 32'h0000_0008);
                rd(A_CLR, v);
                chk("clear_bit", v[3], 1'b1);
                wr(A_CLR, 32'h0000_0000);
                rd(A_CLR, v);
                chk("clear_bit", v[3], 1'b0);
                p0 = pulses;
                wcrc_ctrl_model_inst.send(r.w, |r.fn, 1'b1, d, r.inv, 16'h0000);
                chk("retry_pulses", pulses, p0);
                chk("retry_data", last_d, d);
            end
        end
        rd(wcrc_pkg::REG_ERR_COUNT, v);
        chk("err_count", v, nb);
        wr(wcrc_pkg::REG_CTRL, 32'h0000_0010);
        p0 = pulses;
        a0 = arrs;
        wcrc_ctrl_model_inst.send(2'h1, 1'b0, 1'b0, d, 16'hffff, 16'h0000);
        chk("off_pulses", pulses, p0);
        chk("off_arr", arrs, a0 + 1);
        rd(A_STAT, v);
        chk("off_status", v[0], 1'b0);
        @(posedge clock);
        parity_alert <= 1'b1;
        repeat (3) @(posedge clock);
        parity_alert <= 1'b0;
        wait_pulse(p0);
        chk("parity_width", width, 3);
        rd(A_STAT, v);
        chk("parity_status", v[0], 1'b0);
        finish_test();
    end
endmodule // wcrc_check_tb_top
